// ---- rtl/interval_clock_defines.vh ----
// Purpose: Shared constants for the periodic interval clock block
// Assumes: Register index times four gives the AHB byte address
// Notes: Summary of operation below
`ifndef INTERVAL_CLOCK_DEFINES_VH
`define INTERVAL_CLOCK_DEFINES_VH

// Register indexes; byte address is index times four
`define IDX_CLOCK_GATE 12'hf76
`define IDX_CONTROL 12'hfc8
`define IDX_EVENT_STATUS 12'hfc9
`define IDX_EVENT_MASK 12'hfca
`define IDX_COUNT_VIEW 12'hfcb

// Field positions
`define GATE_ENABLE_BIT 5
`define CTRL_RUN_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 3
`define EV_TICK_BIT 0
`define EV_HALT_BIT 1
`define EV_WIDTH 2

// Reset values
`define CLOCK_GATE_RESET 8'h00
`define SELECT_RESET 3'h0
`define EVENTS_RESET 2'h0

// Counter shape
`define COUNT_WIDTH 15
`define LONGEST_EXP 4'hf

// AHB encodings
`define HSIZE_WORD 3'h2

`endif

// ---- rtl/ahb_reg_port.v ----
// Purpose: AHB-Lite address/data phase tracking for the register file
// Assumes: Zero wait states; hreadyout is always high
// Notes: Reads decode in the address phase, writes land in the data phase
`timescale 1ns/1ps
`default_nettype none
`include "interval_clock_defines.vh"
module ahb_reg_port (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_hsel,
  input wire [15:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire i_hready,
  output wire o_rd_req,
  output wire [11:0] o_rd_index,
  output reg o_wr_req,
  output reg [11:0] o_wr_index
);
  // Only aligned whole-word transfers are taken
  wire take;
  assign take = i_hsel & i_htrans[1] & i_hready & (i_hsize == `HSIZE_WORD)
                & (i_haddr[1:0] == 2'h0);
  assign o_rd_req = take & ~i_hwrite;
  assign o_rd_index = i_haddr[13:2];

  // Write address held for the following data phase
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_req <= 1'b0;
      o_wr_index <= 12'h000;
    end else begin
      o_wr_req <= take & i_hwrite;
      o_wr_index <= i_haddr[13:2];
    end
  end
endmodule // ahb_reg_port
`default_nettype wire

// ---- rtl/interval_counter.v ----
// Purpose: Free-running binary counter with power-of-two interval tick
// Assumes: i_slow_edge is a one-cycle pulse per slow clock rising edge
// Notes: Tick is registered, one cycle after the edge that completes it
`timescale 1ns/1ps
`default_nettype none
`include "interval_clock_defines.vh"
module interval_counter #(
  parameter CNT_W = `COUNT_WIDTH
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_run,
  input wire i_slow_edge,
  input wire [2:0] i_interval_select,
  output reg [CNT_W-1:0] o_count,
  output reg o_tick
);
  // Exponent 15 for code 0 down to 8 for code 7
  wire [3:0] exp_sel;
  wire [CNT_W-1:0] low_mask;
  wire interval_done;
  assign exp_sel = `LONGEST_EXP - {1'b0, i_interval_select};
  assign low_mask = ~({CNT_W{1'b1}} << exp_sel);
  // All bits below the selected power set: next edge ends the interval
  assign interval_done = &(o_count | ~low_mask);

  // Count while running, clear and hold when stopped
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_count <= {CNT_W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run) begin
      o_count <= {CNT_W{1'b0}};
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_slow_edge & interval_done;
      if (i_slow_edge) begin
        o_count <= o_count + {{(CNT_W-1){1'b0}}, 1'b1}; // wraps freely
      end
    end
  end
endmodule // interval_counter
`default_nettype wire

// ---- rtl/periodic_interval_clock.v ----
// Purpose: Periodic interval clock with AHB-Lite register access
// Assumes: Slow clock and mode inputs are synchronous to i_ref_clk
// Notes: Slow clock is sampled and edge-detected, not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "interval_clock_defines.vh"
module periodic_interval_clock #(
  parameter CNT_W = `COUNT_WIDTH
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [15:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // Slow clock and power modes
  input wire i_low_freq_clk,
  input wire i_low_freq_osc_enable,
  input wire i_stop_mode,
  input wire i_deepest_sleep_mode,
  // Results
  output wire o_periodic_interrupt_request,
  output wire o_interval_clock_gate_enable,
  output reg o_irq
);

  // Register state
  reg [7:0] clock_gate_reg;
  reg [7:0] clock_gate_next;
  reg interval_run_reg;
  reg interval_run_next;
  reg [2:0] interval_select_reg;
  reg [2:0] interval_select_next;
  reg [`EV_WIDTH-1:0] event_status_reg;
  reg [`EV_WIDTH-1:0] event_status_next;
  reg [`EV_WIDTH-1:0] event_mask_reg;
  reg [`EV_WIDTH-1:0] event_mask_next;
  reg slow_prev_reg;
  reg [31:0] read_next;

  // Bus front end signals
  wire rd_req;
  wire [11:0] rd_index;
  wire wr_req;
  wire [11:0] wr_index;

  // Counter signals
  wire [CNT_W-1:0] count_value;
  wire interval_tick;

  // Derived controls
  wire gate_enable;
  wire halt_request;
  wire count_enable;
  wire slow_edge;
  wire wr_gate;
  wire wr_control;
  wire wr_status;
  wire wr_mask;
  wire wr_run;
  wire [2:0] wr_select;
  wire halt_event;
  wire [`EV_WIDTH-1:0] event_set;

  // Zero wait states and always OKAY keep the slave simple
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  ahb_reg_port u_port (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hready(i_hready),
    .o_rd_req(rd_req),
    .o_rd_index(rd_index),
    .o_wr_req(wr_req),
    .o_wr_index(wr_index)
  );

  // Gate enable models the base clock switch of the block
  assign gate_enable = clock_gate_reg[`GATE_ENABLE_BIT];
  assign o_interval_clock_gate_enable = gate_enable;

  // Any of these leaves the slow clock unusable for the block
  assign halt_request = ~i_low_freq_osc_enable | i_stop_mode
                        | i_deepest_sleep_mode;

  // Counting needs the gate, the run bit and a live slow clock
  assign count_enable = gate_enable & interval_run_reg & ~halt_request;

  // Rising edge of the sampled slow clock
  assign slow_edge = i_low_freq_clk & ~slow_prev_reg;

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slow_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= i_low_freq_clk;
    end
  end

  interval_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(count_enable),
    .i_slow_edge(slow_edge),
    .i_interval_select(interval_select_reg),
    .o_count(count_value),
    .o_tick(interval_tick)
  );

  // One-cycle pulse per completed interval
  assign o_periodic_interrupt_request = interval_tick;

  // Write decode, data phase
  assign wr_gate = wr_req & (wr_index == `IDX_CLOCK_GATE);
  // Control ignores writes while the base clock is cut
  assign wr_control = wr_req & (wr_index == `IDX_CONTROL) & gate_enable;
  assign wr_status = wr_req & (wr_index == `IDX_EVENT_STATUS);
  assign wr_mask = wr_req & (wr_index == `IDX_EVENT_MASK);
  assign wr_run = i_hwdata[`CTRL_RUN_BIT];
  assign wr_select = i_hwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];

  // Hardware stop of a running block
  assign halt_event = interval_run_reg & halt_request;

  // Events that set sticky status bits
  assign event_set = {halt_event, interval_tick};

  // Power-saving register: every bit plain read/write
  always @* begin
    clock_gate_next = clock_gate_reg;
    if (wr_gate) begin
      clock_gate_next = i_hwdata[7:0];
    end
  end

  // Run bit and interval select
  always @* begin
    interval_run_next = interval_run_reg;
    interval_select_next = interval_select_reg;
    if (wr_control) begin
      if (!interval_run_reg) begin
        // Stopped: select loads, with or without a start
        interval_select_next = wr_select;
      end
      // While running the select write is dropped, old value stays
      interval_run_next = wr_run;
    end
    // Halt beats software start; select is kept
    if (halt_request) begin
      interval_run_next = 1'b0;
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always @* begin
    event_status_next = event_status_reg;
    if (wr_status) begin
      event_status_next = event_status_reg & ~i_hwdata[`EV_WIDTH-1:0];
    end
    event_status_next = event_status_next | event_set;
  end

  // Event mask
  always @* begin
    event_mask_next = event_mask_reg;
    if (wr_mask) begin
      event_mask_next = i_hwdata[`EV_WIDTH-1:0];
    end
  end

  // State registers
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clock_gate_reg <= `CLOCK_GATE_RESET;
      interval_run_reg <= 1'b0;
      interval_select_reg <= `SELECT_RESET;
      event_status_reg <= `EVENTS_RESET;
      event_mask_reg <= `EVENTS_RESET;
    end else begin
      clock_gate_reg <= clock_gate_next;
      interval_run_reg <= interval_run_next;
      interval_select_reg <= interval_select_next;
      event_status_reg <= event_status_next;
      event_mask_reg <= event_mask_next;
    end
  end

  // Interrupt line from a flop; updates on the same edge as the status bit
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(event_status_next & event_mask_next);
    end
  end

  // Read mux; unmapped indexes read zero
  always @* begin
    read_next = 32'h0000_0000;
    if (rd_index == `IDX_CLOCK_GATE) begin
      read_next[7:0] = clock_gate_reg;
    end else if (rd_index == `IDX_CONTROL) begin
      // Upper nibble and bits above stay zero
      read_next[`CTRL_RUN_BIT] = interval_run_reg;
      read_next[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = interval_select_reg;
    end else if (rd_index == `IDX_EVENT_STATUS) begin
      read_next[`EV_WIDTH-1:0] = event_status_reg;
    end else if (rd_index == `IDX_EVENT_MASK) begin
      read_next[`EV_WIDTH-1:0] = event_mask_reg;
    end else if (rd_index == `IDX_COUNT_VIEW) begin
      read_next[CNT_W-1:0] = count_value;
    end
  end

  // Read data captured in the address phase, shown in the data phase
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      o_hrdata <= read_next;
    end
  end

endmodule // periodic_interval_clock
`default_nettype wire

// ---- testbench/periodic_interval_clock_monitor.sv ----
// Purpose: Port-level assertions for the periodic interval clock
// Assumes: Slow clock stays high and low one ref cycle or more
// Notes: Bound into the design from tb_top
`timescale 1ns/1ps
`default_nettype none
module periodic_interval_clock_monitor (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [15:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_low_freq_osc_enable,
  input wire logic i_stop_mode,
  input wire logic i_deepest_sleep_mode,
  input wire logic o_periodic_interrupt_request,
  input wire logic o_interval_clock_gate_enable,
  input wire logic o_irq
);
  // Short aliases for outputs, bus requests and halt causes
  wire tick = o_periodic_interrupt_request;
  wire gate = o_interval_clock_gate_enable;
  wire wr = i_hsel && i_hwrite && i_htrans[1];
  wire gate_wr = wr && i_hsize == 3'h2 && i_haddr == 16'h3dd8;
  wire halt = !i_low_freq_osc_enable || i_stop_mode || i_deepest_sleep_mode;
  logic [9:0] gap_reg;
  // Cycles since last tick; saturates so the first tick is not judged
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_reg <= 10'h3ff;
    end else if (tick) begin
      gap_reg <= 10'h000;
    end else if (gap_reg != 10'h3ff) begin
      gap_reg <= gap_reg + 10'h001;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  AST_RESET_CLEAR: assert property ($past(i_sys_rst) |-> !gate && !o_irq && !tick)
    else $error("outputs not clear after reset");
  AST_TICK_SINGLE: assert property (tick |=> !tick)
    else $error("tick longer than one cycle");
  // Shortest interval is 256 slow edges of two ref cycles at least
  AST_TICK_SPACING: assert property (tick |-> gap_reg >= 10'd511)
    else $error("ticks closer than shortest interval");
  AST_GATE_OFF_QUIET: assert property (!gate && !$past(gate) && !$past(gate, 2) |-> !tick)
    else $error("tick while gated off");
  AST_HALT_QUIET: assert property (halt && $past(halt) && $past(halt, 2) |-> !tick)
    else $error("tick while halted");
  AST_GATE_WRITE: assert property ($changed(gate) |-> $past(gate_wr, 2) && gate == $past(i_hwdata[5]))
    else $error("gate bit changed without a matching write");
  AST_IRQ_RISE: assert property ($rose(o_irq) |-> $past(tick) || $past(wr, 2) || $past(wr, 3)
    || $past(halt) || $past(halt, 2))
    else $error("irq rose without a cause");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(wr, 2) || $past(wr, 3))
    else $error("irq fell without a write");
endmodule // periodic_interval_clock_monitor
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the periodic interval clock
// Assumes: Zero-wait AHB slave, slow clock a quarter of the ref rate
// Notes: Random intervals kept short to bound the run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, hsel, hwrite, lf_en, osc, stop, sleep;
  logic [15:0] haddr;
  logic [1:0] htrans, div_reg;
  logic [2:0] hsize, s;
  logic [31:0] hwdata, rd, seed;
  wire [31:0] hrdata;
  wire hready, hresp, pulse, gate, irq;
  int errors, checked, n;
  periodic_interval_clock dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_low_freq_clk(div_reg[1]),
    .i_low_freq_osc_enable(osc), .i_stop_mode(stop), .i_deepest_sleep_mode(sleep),
    .o_periodic_interrupt_request(pulse), .o_interval_clock_gate_enable(gate), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Slow clock, four ref cycles a period, still while disabled
  always @(posedge clk) begin
    if (lf_en) begin
      div_reg <= div_reg + 2'h1;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Ref cycles between ticks for a select code
  function automatic logic [31:0] period(input logic [2:0] c);
    return 32'h4 << (4'hf - c);
  endfunction
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checked++;
    if (v !== e) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, v, e);
    end
  endtask
  // One AHB single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Sampled on the falling edge, clear of the tick's own update
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (pulse !== 1'b1 && c < 20000);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(50 * 90000);
    errors++;
    summarize;
  end
  initial begin
    {rst, hsize, seed} = {1'b1, 3'h2, 32'h1de1ed62};
    {hsel, haddr, htrans, hwrite, hwdata, lf_en, div_reg} = '0;
    {osc, stop, sleep} = 3'b100;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(16'h3dd8, 32'h0);
    rchk(16'h3f20, 32'h0);
    bus(1'b1, 16'h3f20, 32'hf);
    rchk(16'h3f20, 32'h0);
    rchk(16'h0100, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    seed = xs(seed);
    bus(1'b1, 16'h3dd8, {24'h0, seed[7:0] | 8'h20}); // Set once, never cleared
    rchk(16'h3dd8, {24'h0, seed[7:0] | 8'h20});
    chk({31'h0, gate}, 32'h1);
    $display("test registers done");
    bus(1'b1, 16'h3f28, 32'h3);
    lf_en <= 1'b1;
    bus(1'b1, 16'h3f20, 32'hff);
    rchk(16'h3f20, 32'hf);
    bus(1'b1, 16'h3f20, 32'h3);
    rchk(16'h3f20, 32'hf);
    wait_pulse(n);
    wait_pulse(n);
    chk(n, period(3'h7));
    rchk(16'h3f24, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 16'h3f24, 32'h1);
    rchk(16'h3f24, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 16'h3f20, 32'h0);
    rchk(16'h3f20, 32'he);
    repeat (40) @(posedge clk);
    rchk(16'h3f2c, 32'h0);
    $display("test start and stop done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      s = {1'b1, seed[1:0]};
      bus(1'b1, 16'h3f20, {28'h0, s, 1'b1});
      wait_pulse(n);
      wait_pulse(n);
      chk(n, period(s));
      bus(1'b1, 16'h3f20, 32'h0);
    end
    $display("test random intervals done");
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 16'h3f24, 32'h3);
      bus(1'b1, 16'h3f20, 32'h7);
      {osc, stop, sleep} <= {k != 0, k == 1, k == 2};
      repeat (4) @(posedge clk);
      rchk(16'h3f20, 32'h6);
      rchk(16'h3f24, 32'h2);
      {osc, stop, sleep} <= 3'b100;
    end
    bus(1'b1, 16'h3f28, 32'h0);
    rchk(16'h3f24, 32'h2);
    chk({31'h0, irq}, 32'h0);
    $display("test halts and mask done");
    summarize;
  end
endmodule // tb_top
bind periodic_interval_clock periodic_interval_clock_monitor mon (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_low_freq_osc_enable(i_low_freq_osc_enable), .i_stop_mode(i_stop_mode),
  .i_deepest_sleep_mode(i_deepest_sleep_mode),
  .o_periodic_interrupt_request(o_periodic_interrupt_request),
  .o_interval_clock_gate_enable(o_interval_clock_gate_enable), .o_irq(o_irq));
`default_nettype wire
